// ==== src/doc_pkg.sv ====
package doc_pkg;
    // serial frame: one read flag, fifteen address bits, eight data bits
    localparam int ADDR_W = 15;
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h0f;
    localparam logic [4:0] CNT_DATA_FIRST = 5'h10;
    localparam logic [4:0] CNT_DATA_LAST = 5'h17;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_CHAN_FACTOR_LO = 15'h0167;
    localparam logic [ADDR_W-1:0] ADDR_CHAN_FACTOR_HI = 15'h0168;
    localparam logic [ADDR_W-1:0] ADDR_CHANNEL_DECIMATION_CONFIG = 15'h0169;
    localparam logic [ADDR_W-1:0] ADDR_SAMPLING_ZONE_CONFIG = 15'h016b;
    localparam logic [ADDR_W-1:0] ADDR_OSC_ARRAY_FIRST = 15'h0200;
    localparam logic [ADDR_W-1:0] ADDR_OSC_ARRAY_LAST = 15'h02df;
    localparam logic [ADDR_W-1:0] ADDR_BIT_CLOCK_DIVIDER_CTRL = 15'h0590;
    localparam logic [ADDR_W-1:0] ADDR_LANE_POWERDOWN_UPPER = 15'h0691;
    localparam logic [ADDR_W-1:0] ADDR_LANE_POWERDOWN_LOWER = 15'h0692;

    // channel_decimation_config fields
    localparam int POS_PER_CHANNEL_EN = 7;
    localparam int POS_COUNT_LSB = 4;
    localparam int POS_COMMON_LSB = 0;

    // active channel count codes
    localparam logic [1:0] COUNT_DUAL = 2'h0;
    localparam logic [1:0] COUNT_QUAD = 2'h1;
    localparam logic [1:0] COUNT_SINGLE = 2'h2;
    localparam logic [3:0] CHAN_MASK_DUAL = 4'h3;
    localparam logic [3:0] CHAN_MASK_QUAD = 4'hf;
    localparam logic [3:0] CHAN_MASK_SINGLE = 4'h1;
    localparam logic [3:0] CHAN_MASK_NONE = 4'h0;

    // sampling_zone_config fields
    localparam int POS_ZONE_STROBE = 4;
    localparam int POS_ZONE_LSB = 0;
    localparam logic [2:0] ZONE_LAST_VALID = 3'h5;

    // bit_clock_divider_ctrl field
    localparam int POS_DIV_EN = 1;

    // lane power-down fields
    localparam int POS_CLK_PDN = 4;

    // oscillator array packing
    localparam int NUM_CHAN = 4;
    localparam int NUM_WORDS = 4;
    localparam int FREQ_BYTES = 6;
    localparam int PHASE_BYTES = 2;
    localparam int FREQ_AREA = NUM_CHAN * NUM_WORDS * FREQ_BYTES;
    localparam int OSC_BYTES = FREQ_AREA + NUM_CHAN * NUM_WORDS * PHASE_BYTES;

    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// ==== src/doc_regs.sv ====
// Summary of operation
// - bit 7 low: one shared factor everywhere
// - count code: 00 dual, 01 quad, 10 single
// - factor code n decimates by two to n
// - strobe rising edge latches the zone field
// - zone codes 000..101 valid, others unused
// - four 48-bit words per channel, little endian
// - 16-bit start phase per word, little endian
// - divider enable bit drives bit clock divider
// - lane power-down bit disables that lane
// - clock power-down bit disables output clock
// - per-channel mode uses per-channel factor fields
module doc_regs
    import doc_pkg::*;
(
    input wire logic clk_i, // converter clock
    input wire logic arst_n_i, // async reset, active low
    input wire logic spi_sclk_i, // serial clock pin
    input wire logic spi_cs_n_i, // chip select, active low
    input wire logic spi_sdi_i, // serial data in
    output logic spi_sdo_o, // serial data out
    output logic spi_sdo_oe_o, // serial data out enable
    input wire logic [2*NUM_CHAN-1:0] osc_sel_i, // active word per channel
    output logic [NUM_CHAN-1:0] channel_active_o, // channel enabled
    output logic [4*NUM_CHAN-1:0] dec_code_o, // decimation code per channel
    output logic count_invalid_o, // unused count code set
    output logic [2:0] zone_latched_o, // zone used by calibration
    output logic zone_valid_o, // latched zone is defined
    output logic [48*NUM_CHAN-1:0] osc_freq_word_o, // selected frequency words
    output logic [16*NUM_CHAN-1:0] osc_phase_word_o, // selected phase words
    output logic bit_clock_divider_enable_o, // bit clock divider on
    output logic [7:0] lane_powerdown_o, // lane n powered down
    output logic output_clock_powerdown_o // output clock powered down
);
    logic wr, rd; // port strobes
    logic [ADDR_W-1:0] addr; // port address
    logic [7:0] wdata; // port write data
    logic [7:0] rdata; // read mux
    logic [7:0] chan_dec, next_chan_dec; // channel_decimation_config
    logic [7:0] chan_factor_lo, next_chan_factor_lo; // factors ch0, ch1
    logic [7:0] chan_factor_hi, next_chan_factor_hi; // factors ch2, ch3
    logic [7:0] zone_cfg, next_zone_cfg; // sampling_zone_config
    logic strobe_d, next_strobe_d; // strobe one cycle ago
    logic [2:0] next_zone_latched;
    logic [7:0] div_ctrl, next_div_ctrl; // bit_clock_divider_ctrl
    logic [7:0] pdn_upper, next_pdn_upper; // lane_powerdown_upper
    logic [7:0] pdn_lower, next_pdn_lower; // lane_powerdown_lower
    logic [7:0] osc_mem [OSC_BYTES]; // oscillator_word_array
    logic in_osc; // address inside the array window
    logic [ADDR_W-1:0] osc_off; // offset into the array window
    logic [3:0] next_active;
    logic [4*NUM_CHAN-1:0] next_dec;
    logic [7:0] next_lanes;

    doc_serial_port u_port (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .sclk_i(spi_sclk_i),
        .cs_n_i(spi_cs_n_i),
        .sdi_i(spi_sdi_i),
        .rdata_i(rdata),
        .sdo_o(spi_sdo_o),
        .sdo_oe_o(spi_sdo_oe_o),
        .wr_o(wr),
        .rd_o(rd),
        .addr_o(addr),
        .wdata_o(wdata)
    );

    assign in_osc = (addr >= ADDR_OSC_ARRAY_FIRST) && (addr <= ADDR_OSC_ARRAY_LAST);
    assign osc_off = addr - ADDR_OSC_ARRAY_FIRST;

    // register writes and zone latch
    always_comb begin
        next_chan_dec = chan_dec;
        next_chan_factor_lo = chan_factor_lo;
        next_chan_factor_hi = chan_factor_hi;
        next_zone_cfg = zone_cfg;
        next_div_ctrl = div_ctrl;
        next_pdn_upper = pdn_upper;
        next_pdn_lower = pdn_lower;
        next_strobe_d = zone_cfg[POS_ZONE_STROBE];
        next_zone_latched = zone_latched_o;
        if (wr) begin
            case (addr)
                ADDR_CHANNEL_DECIMATION_CONFIG: next_chan_dec = wdata & 8'hbf;
                ADDR_CHAN_FACTOR_LO: next_chan_factor_lo = wdata;
                ADDR_CHAN_FACTOR_HI: next_chan_factor_hi = wdata;
                ADDR_SAMPLING_ZONE_CONFIG: next_zone_cfg = wdata & 8'h17;
                ADDR_BIT_CLOCK_DIVIDER_CTRL: next_div_ctrl = wdata & 8'h02;
                ADDR_LANE_POWERDOWN_UPPER: next_pdn_upper = wdata & 8'hf0;
                ADDR_LANE_POWERDOWN_LOWER: next_pdn_lower = wdata & 8'h1f;
                default: next_chan_dec = chan_dec;
            endcase
        end
        if (zone_cfg[POS_ZONE_STROBE] && !strobe_d) begin
            next_zone_latched = zone_cfg[POS_ZONE_LSB +: 3];
        end
    end

    // control registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_dec <= RESET_BYTE;
            chan_factor_lo <= RESET_BYTE;
            chan_factor_hi <= RESET_BYTE;
            zone_cfg <= RESET_BYTE;
            div_ctrl <= RESET_BYTE;
            pdn_upper <= RESET_BYTE;
            pdn_lower <= RESET_BYTE;
            strobe_d <= 1'b0;
            zone_latched_o <= 3'h0;
        end else begin
            chan_dec <= next_chan_dec;
            chan_factor_lo <= next_chan_factor_lo;
            chan_factor_hi <= next_chan_factor_hi;
            zone_cfg <= next_zone_cfg;
            div_ctrl <= next_div_ctrl;
            pdn_upper <= next_pdn_upper;
            pdn_lower <= next_pdn_lower;
            strobe_d <= next_strobe_d;
            zone_latched_o <= next_zone_latched;
        end
    end

    // byte array written at its packed offset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < OSC_BYTES; i++) begin
                osc_mem[i] <= RESET_BYTE;
            end
        end else if (wr && in_osc && osc_off < ADDR_W'(OSC_BYTES)) begin
            osc_mem[osc_off[6:0]] <= wdata;
        end
    end

    // read mux
    always_comb begin
        rdata = RESET_BYTE;
        case (addr)
            ADDR_CHANNEL_DECIMATION_CONFIG: rdata = chan_dec;
            ADDR_CHAN_FACTOR_LO: rdata = chan_factor_lo;
            ADDR_CHAN_FACTOR_HI: rdata = chan_factor_hi;
            ADDR_SAMPLING_ZONE_CONFIG: rdata = zone_cfg;
            ADDR_BIT_CLOCK_DIVIDER_CTRL: rdata = div_ctrl;
            ADDR_LANE_POWERDOWN_UPPER: rdata = pdn_upper;
            ADDR_LANE_POWERDOWN_LOWER: rdata = pdn_lower;
            default: begin
                if (in_osc && osc_off < ADDR_W'(OSC_BYTES)) begin
                    rdata = osc_mem[osc_off[6:0]];
                end
            end
        endcase
    end

    // channel enables, factors and lane map
    always_comb begin
        case (chan_dec[POS_COUNT_LSB +: 2])
            COUNT_DUAL: next_active = CHAN_MASK_DUAL;
            COUNT_QUAD: next_active = CHAN_MASK_QUAD;
            COUNT_SINGLE: next_active = CHAN_MASK_SINGLE;
            default: next_active = CHAN_MASK_NONE;
        endcase
        if (chan_dec[POS_PER_CHANNEL_EN]) begin
            next_dec = {chan_factor_hi, chan_factor_lo};
        end else begin
            next_dec = {NUM_CHAN{chan_dec[POS_COMMON_LSB +: 4]}};
        end
        // lane order of the two registers
        next_lanes = {pdn_upper[5], pdn_upper[6], pdn_upper[7],
                      pdn_lower[0], pdn_lower[1], pdn_lower[2], pdn_lower[3], pdn_lower[4]};
    end

    // registered datapath controls
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            channel_active_o <= CHAN_MASK_DUAL;
            dec_code_o <= 16'h0000;
            count_invalid_o <= 1'b0;
            zone_valid_o <= 1'b1;
            bit_clock_divider_enable_o <= 1'b0;
            lane_powerdown_o <= 8'h00;
            output_clock_powerdown_o <= 1'b0;
        end else begin
            channel_active_o <= next_active;
            dec_code_o <= next_dec;
            count_invalid_o <= (next_active == CHAN_MASK_NONE);
            zone_valid_o <= (next_zone_latched <= ZONE_LAST_VALID);
            bit_clock_divider_enable_o <= div_ctrl[POS_DIV_EN];
            lane_powerdown_o <= next_lanes;
            output_clock_powerdown_o <= pdn_upper[POS_CLK_PDN];
        end
    end

    // per-channel word selection
    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            logic [47:0] next_freq;
            logic [15:0] next_phase;
            logic [6:0] fbase;
            logic [6:0] pbase;
            always_comb begin
                fbase = 7'((c * NUM_WORDS + int'(osc_sel_i[2*c +: 2])) * FREQ_BYTES);
                pbase = 7'(FREQ_AREA + (c * NUM_WORDS + int'(osc_sel_i[2*c +: 2])) * PHASE_BYTES);
                next_freq = 48'h000000000000;
                for (int b = 0; b < FREQ_BYTES; b++) begin
                    next_freq[8*b +: 8] = osc_mem[fbase + 7'(b)];
                end
                next_phase = {osc_mem[pbase + 7'h01], osc_mem[pbase]};
            end
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    osc_freq_word_o[48*c +: 48] <= 48'h000000000000;
                    osc_phase_word_o[16*c +: 16] <= 16'h0000;
                end else begin
                    osc_freq_word_o[48*c +: 48] <= next_freq;
                    osc_phase_word_o[16*c +: 16] <= next_phase;
                end
            end
        end
    endgenerate

    property p_common_factor;
        @(posedge clk_i) disable iff (!arst_n_i)
        !chan_dec[POS_PER_CHANNEL_EN] |=> dec_code_o[15:12] == $past(chan_dec[3:0]);
    endproperty
    a_common_factor: assert property (p_common_factor) else $error("shared factor not applied");

    property p_count;
        @(posedge clk_i) disable iff (!arst_n_i)
        chan_dec[5:4] == COUNT_SINGLE |=> channel_active_o == CHAN_MASK_SINGLE;
    endproperty
    a_count: assert property (p_count) else $error("single count not decoded");

    property p_bypass;
        @(posedge clk_i) disable iff (!arst_n_i)
        (chan_dec == 8'h00) ##1 (chan_dec == 8'h00) |-> dec_code_o == 16'h0000;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass code not shared");

    property p_zone_latch;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(zone_cfg[POS_ZONE_STROBE]) |=> zone_latched_o == $past(zone_cfg[2:0]);
    endproperty
    a_zone_latch: assert property (p_zone_latch) else $error("zone not latched");

    property p_zone_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        !(zone_cfg[POS_ZONE_STROBE] && !strobe_d) |=> $stable(zone_latched_o);
    endproperty
    a_zone_hold: assert property (p_zone_hold) else $error("zone changed without strobe");

    property p_zone_valid;
        @(posedge clk_i) disable iff (!arst_n_i)
        ##1 zone_latched_o > ZONE_LAST_VALID |-> !zone_valid_o;
    endproperty
    a_zone_valid: assert property (p_zone_valid) else $error("unused zone flagged valid");

    property p_divider;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr && addr == ADDR_BIT_CLOCK_DIVIDER_CTRL |=> ##1 bit_clock_divider_enable_o == $past(wdata[1], 2);
    endproperty
    a_divider: assert property (p_divider) else $error("divider enable wrong");

    property p_lane;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr && addr == ADDR_LANE_POWERDOWN_LOWER |=> ##1 lane_powerdown_o[0] == $past(wdata[4], 2);
    endproperty
    a_lane: assert property (p_lane) else $error("lane zero power-down wrong");

    property p_clk_pdn;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr && addr == ADDR_LANE_POWERDOWN_UPPER |=> ##1 output_clock_powerdown_o == $past(wdata[4], 2);
    endproperty
    a_clk_pdn: assert property (p_clk_pdn) else $error("clock power-down wrong");

    property p_lane_upper;
        @(posedge clk_i) disable iff (!arst_n_i)
        wr && addr == ADDR_LANE_POWERDOWN_UPPER |=> ##1 lane_powerdown_o[7] == $past(wdata[5], 2);
    endproperty
    a_lane_upper: assert property (p_lane_upper) else $error("lane seven state wrong");

    property p_own_factor;
        @(posedge clk_i) disable iff (!arst_n_i)
        chan_dec[POS_PER_CHANNEL_EN] |=> dec_code_o[7:0] == $past(chan_factor_lo);
    endproperty
    a_own_factor: assert property (p_own_factor) else $error("own factors not applied");

    property p_reserved;
        @(posedge clk_i) disable iff (!arst_n_i)
        addr == ADDR_CHANNEL_DECIMATION_CONFIG |-> rdata[6] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit reads one");
endmodule

// ==== src/doc_serial_port.sv ====
// serial configuration port: frames of read flag, address and data
module doc_serial_port
    import doc_pkg::*;
(
    input wire logic clk_i, // converter clock
    input wire logic arst_n_i, // async reset, active low
    input wire logic sclk_i, // serial clock pin
    input wire logic cs_n_i, // chip select pin, active low
    input wire logic sdi_i, // serial data in pin
    input wire logic [7:0] rdata_i, // read data for addr_o
    output logic sdo_o, // serial data out
    output logic sdo_oe_o, // serial data out enable
    output logic wr_o, // write pulse
    output logic rd_o, // read pulse
    output logic [ADDR_W-1:0] addr_o, // register address
    output logic [7:0] wdata_o // write data
);
    logic [1:0] sclk_s; // pin synchronisers
    logic [1:0] cs_s;
    logic [1:0] sdi_s;
    logic sclk_d; // previous synced clock
    logic [4:0] cnt, next_cnt; // bits taken in this frame
    logic [22:0] shin, next_shin; // shift-in register
    logic [7:0] shout, next_shout; // shift-out register
    logic rmode, next_rmode; // frame is a read
    logic next_wr, next_rd;
    logic [ADDR_W-1:0] next_addr;
    logic [7:0] next_wdata;
    logic rise, fall, active;

    // two flops per pin before any logic
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_s <= 2'h0;
            cs_s <= 2'h3;
            sdi_s <= 2'h0;
            sclk_d <= 1'b0;
        end else begin
            sclk_s <= {sclk_s[0], sclk_i};
            cs_s <= {cs_s[0], cs_n_i};
            sdi_s <= {sdi_s[0], sdi_i};
            sclk_d <= sclk_s[1];
        end
    end

    assign rise = sclk_s[1] & ~sclk_d;
    assign fall = ~sclk_s[1] & sclk_d;
    assign active = ~cs_s[1];

    // frame sequencing
    always_comb begin
        next_cnt = cnt;
        next_shin = shin;
        next_shout = shout;
        next_rmode = rmode;
        next_wr = 1'b0;
        next_rd = 1'b0;
        next_addr = addr_o;
        next_wdata = wdata_o;
        if (rd_o) begin
            // capture the addressed byte
            next_shout = rdata_i;
        end
        if (!active) begin
            // deselect aborts a partial frame
            next_cnt = 5'h00;
            next_rmode = 1'b0;
        end else if (rise) begin
            next_shin = {shin[21:0], sdi_s[1]};
            if (cnt != CNT_DATA_LAST + 5'h01) begin
                next_cnt = cnt + 5'h01;
            end
            if (cnt == CNT_ADDR_LAST) begin
                // header complete
                next_addr = {shin[13:0], sdi_s[1]};
                next_rmode = shin[14];
                next_rd = shin[14];
            end
            if (cnt == CNT_DATA_LAST && !rmode) begin
                next_wdata = {shin[6:0], sdi_s[1]};
                next_wr = 1'b1;
            end
        end else if (fall && rmode && cnt > CNT_DATA_FIRST) begin
            // next read bit, msb first
            next_shout = {shout[6:0], 1'b0};
        end
    end

    // frame state registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 5'h00;
            shin <= 23'h000000;
            shout <= RESET_BYTE;
            rmode <= 1'b0;
            wr_o <= 1'b0;
            rd_o <= 1'b0;
            addr_o <= 15'h0000;
            wdata_o <= RESET_BYTE;
        end else begin
            cnt <= next_cnt;
            shin <= next_shin;
            shout <= next_shout;
            rmode <= next_rmode;
            wr_o <= next_wr;
            rd_o <= next_rd;
            addr_o <= next_addr;
            wdata_o <= next_wdata;
        end
    end

    assign sdo_o = shout[7];
    assign sdo_oe_o = active & rmode & (cnt >= CNT_DATA_FIRST);
endmodule

// ==== testbench/doc_host_model.sv ====
// host controller on the serial configuration port
module doc_host_model (
    input wire logic clk_i, // converter clock
    output logic sclk_o, // serial clock to device
    output logic cs_n_o, // chip select, active low
    output logic sdi_o, // serial data to device
    input wire logic sdo_i // serial data from device
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle levels before the first frame
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // one 24-bit frame, msb first; levels of six clocks keep the synchroniser happy
    task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                         output logic [7:0] rdat);
        logic [23:0] sh;
        sh = {rd, addr, wd};
        rdat = 8'h00;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi_o <= sh[i];
            repeat (5) @(posedge clk_i);
            // sample read data mid-cycle, well after the device shifted it
            @(negedge clk_i);
            if (i < 8) begin
                rdat[i] = sdo_i;
            end
            @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (6) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        cs_n_o <= 1'b1;
        // released data line must not look like the last bit
        sdi_o <= ~sh[0];
        repeat (6) @(posedge clk_i);
    endtask

    // register write
    task automatic wr(input logic [14:0] addr, input logic [7:0] wd);
        logic [7:0] dummy;
        frame(1'b0, addr, wd, dummy);
    endtask

    // register read
    task automatic rd(input logic [14:0] addr, output logic [7:0] rdat);
        frame(1'b1, addr, 8'h00, rdat);
    endtask

    task automatic set_zone(input logic [2:0] zone);
        wr(15'h016b, {5'h00, zone});
        wr(15'h016b, {5'h02, zone});
    endtask
endmodule

// ==== testbench/tb_ddc_output_config_regs.sv ====
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", name, exp, got); end end

// self-checking bench for the configuration register bank
module tb_ddc_output_config_regs;
    import doc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i = 1'b0; // converter clock
    logic arst_n_i = 1'b0; // reset, active low
    logic sclk, cs_n, sdi, sdo, sdo_oe; // serial port wires
    logic [7:0] osc_sel = 8'h00; // word select per channel
    logic [3:0] chan_act; // active channel mask
    logic [15:0] dec_code; // decimation codes
    logic cnt_inv, zone_ok, div_en, clk_pdn; // single flags
    logic [2:0] zone; // latched zone
    logic [191:0] freq; // selected frequency words
    logic [63:0] phase; // selected phase words
    logic [7:0] lanes, rb; // lane power-down, read-back byte
    int n_errors = 0; // mismatch counter
    int checks_done = 0; // comparison counter
    int cycles = 0; // timeout counter
    int oe_hits = 0; // cycles with read data driven
    // rows of address, written byte, expected read-back
    localparam logic [30:0] ROWS [11] = '{
        {15'h0169, 8'hff, 8'hbf}, {15'h016b, 8'hff, 8'h17}, {15'h0590, 8'hff, 8'h02},
        {15'h0691, 8'hff, 8'hf0}, {15'h0692, 8'hff, 8'h1f}, {15'h0167, 8'h5a, 8'h5a},
        {15'h0168, 8'hc3, 8'hc3}, {15'h0200, 8'h11, 8'h11}, {15'h025f, 8'h22, 8'h22},
        {15'h02df, 8'h33, 8'h00}, {15'h0170, 8'h44, 8'h00}};
    localparam logic [3:0] FACS [4] = '{4'h0, 4'h1, 4'he, 4'hf}; // factor per count step
    localparam logic [3:0] MASKS [4] = '{CHAN_MASK_DUAL, CHAN_MASK_QUAD, CHAN_MASK_SINGLE,
                                         CHAN_MASK_NONE};

    // clock generator
    always #12.5 clk_i = ~clk_i;

    doc_regs doc_regs_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
        .osc_sel_i(osc_sel), .channel_active_o(chan_act), .dec_code_o(dec_code),
        .count_invalid_o(cnt_inv), .zone_latched_o(zone), .zone_valid_o(zone_ok),
        .osc_freq_word_o(freq), .osc_phase_word_o(phase), .bit_clock_divider_enable_o(div_en),
        .lane_powerdown_o(lanes), .output_clock_powerdown_o(clk_pdn));

    doc_host_model doc_host_model_inst (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n),
        .sdi_o(sdi), .sdo_i(sdo));

    // verdict and end of run
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard, well above the expected run length
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (sdo_oe) begin
            oe_hits <= oe_hits + 1;
        end
        if (cycles == 40000) begin
            n_errors++;
            summarize();
        end
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        doc_host_model_inst.rd(ADDR_CHANNEL_DECIMATION_CONFIG, rb);
        `CHK("reset config", 8'h00, rb)
        `CHK("read drive", 1'b1, oe_hits > 0)
        `CHK("drive released", 1'b0, sdo_oe)
        `CHK("reset mask", CHAN_MASK_DUAL, chan_act)
        // write and read back every row
        for (int r = 0; r < 11; r++) begin
            doc_host_model_inst.wr(ROWS[r][30:16], ROWS[r][15:8]);
            doc_host_model_inst.rd(ROWS[r][30:16], rb);
            `CHK("readback", ROWS[r][7:0], rb)
        end
        `CHK("divider on", 1'b1, div_en)
        `CHK("all lanes down", 8'hff, lanes)
        `CHK("clock down", 1'b1, clk_pdn)
        `CHK("zone seven latched", 3'h7, zone)
        `CHK("zone seven unused", 1'b0, zone_ok)
        // every count code with a shared factor
        for (int c = 0; c < 4; c++) begin
            doc_host_model_inst.wr(ADDR_CHANNEL_DECIMATION_CONFIG, {2'b00, 2'(c), FACS[c]});
            `CHK("active mask", MASKS[c], chan_act)
            `CHK("count unused", (c == 3), cnt_inv)
            `CHK("shared factor", {4{FACS[c]}}, dec_code)
        end
        doc_host_model_inst.wr(ADDR_CHANNEL_DECIMATION_CONFIG, 8'h90);
        `CHK("own factors", 16'hc35a, dec_code)
        doc_host_model_inst.wr(ADDR_CHANNEL_DECIMATION_CONFIG, 8'h12);
        `CHK("back to shared", 16'h2222, dec_code)
        // zone field alone, then strobe, then strobe held high
        doc_host_model_inst.wr(ADDR_SAMPLING_ZONE_CONFIG, 8'h03);
        `CHK("zone not latched", 3'h7, zone)
        doc_host_model_inst.set_zone(3'h3);
        `CHK("zone latched", 3'h3, zone)
        `CHK("zone valid", 1'b1, zone_ok)
        doc_host_model_inst.wr(ADDR_SAMPLING_ZONE_CONFIG, 8'h16);
        `CHK("no relatch", 3'h3, zone)
        doc_host_model_inst.set_zone(3'h5);
        `CHK("last zone valid", 1'b1, zone_ok)
        // channel 1 word 2: frequency bytes lsb first, then phase
        for (int b = 0; b < 6; b++) begin
            doc_host_model_inst.wr(15'h0224 + 15'(b), 8'(b + 1));
        end
        doc_host_model_inst.wr(15'h026c, 8'h34);
        doc_host_model_inst.wr(15'h026d, 8'h12);
        @(posedge clk_i);
        osc_sel <= 8'h08;
        repeat (3) @(posedge clk_i);
        `CHK("freq word", 48'h060504030201, freq[95:48])
        `CHK("phase word", 16'h1234, phase[31:16])
        // single lanes and clock back on
        doc_host_model_inst.wr(ADDR_LANE_POWERDOWN_UPPER, 8'h40);
        doc_host_model_inst.wr(ADDR_LANE_POWERDOWN_LOWER, 8'h01);
        doc_host_model_inst.wr(ADDR_BIT_CLOCK_DIVIDER_CTRL, 8'h00);
        `CHK("lane map", 8'h50, lanes)
        `CHK("clock up", 1'b0, clk_pdn)
        `CHK("divider off", 1'b0, div_en)
        // second reset in mid-run
        doc_host_model_inst.wr(ADDR_LANE_POWERDOWN_LOWER, 8'h1f);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK("lanes after reset", 8'h00, lanes)
        arst_n_i <= 1'b1;
        doc_host_model_inst.rd(ADDR_LANE_POWERDOWN_LOWER, rb);
        `CHK("lower after reset", 8'h00, rb)
        summarize();
    end
endmodule
